// File: design/err_bus_init_n_pkg.sv
package err_bus_init_n_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] OFS_ERR_STATUS    = 4'h0;
    localparam logic [3:0] OFS_FIRST_LOG     = 4'h1;
    localparam logic [3:0] OFS_SECOND_LOG    = 4'h2;
    localparam logic [3:0] OFS_CAPTURED_CFG  = 4'h3;
    localparam logic [3:0] OFS_DRIVEN_CFG    = 4'h4;
    localparam logic [3:0] OFS_ERR_CLEAR     = 4'h5;
    localparam logic [3:0] OFS_ERR_INJECT    = 4'h6;
    // Field positions
    localparam int BIT_BUS_INIT_EN           = 10;
    localparam int BIT_PARITY_ERR            = 0;
    localparam int BIT_BUS_INIT_N_ON_ERR          = 0;
    localparam int BIT_CAPTURED_BUS_INIT_N        = 1;
    // Reset values
    localparam logic [15:0] RST_DRIVEN_CFG   = 16'h0000;
    localparam logic [15:0] RST_ERR_STATUS   = 16'h0000;
    localparam logic [15:0] RST_LOG          = 16'h0000;
    // Cycles of internal reset after a bus-init event
    localparam logic [3:0] BUS_INIT_N_RESET_CYC   = 4'h8;
    // Internal reset phases
    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_INIT   = 3'b010,
        ST_SETTLE = 3'b100
    } init_state_t;
endpackage : err_bus_init_n_pkg

// File: design/error_pin_bus_init_n_config.sv
// The address map and the strobed register port were decided locally.
module error_pin_bus_init_n_config
    import err_bus_init_n_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [15:0] reg_rdata_out,
    // Error events
    input  wire logic        expander_parity_err_in,
    input  wire logic        first_err_evt_in,
    input  wire logic [15:0] first_err_info_in,
    input  wire logic        second_err_evt_in,
    input  wire logic [15:0] second_err_info_in,
    // System reset and bus-init
    input  wire logic        sys_reset_in,
    input  wire logic        bus_init_n_in,
    output logic             bus_init_n_out,
    output logic             bus_init_n_oe_out,
    input  wire logic        addr10_in,
    output logic             addr10_out,
    output logic             addr10_oe_out,
    // Monitor pins and internal reset indication
    output logic      [1:0]  err_n_out,
    output logic             chip_reset_out
);

    logic [15:0]  error_status_reg;
    logic [15:0]  first_error_log;
    logic [15:0]  second_error_log;
    logic [15:0]  driven_config_reg;
    logic [15:0]  captured_config_reg;
    logic [15:0]  error_command_reg;
    init_state_t  state;
    logic [3:0]   init_cnt;
    logic         sys_reset_q;
    logic         bus_init_seen;

    // Decode of a write to one register
    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] o,
                                    input logic w);
        return w && (a == o);
    endfunction : wr_hit

    // Bus-init is taken whatever the captured enable bit says
    assign bus_init_seen = !bus_init_n_in;

    // Internal reset sequence after bus-init; never touches sticky bits
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            state    <= ST_RUN;
            init_cnt <= 4'h0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (bus_init_seen)
                    begin
                        state    <= ST_INIT;
                        init_cnt <= BUS_INIT_N_RESET_CYC;
                    end
                end
                ST_INIT:
                begin
                    if (init_cnt == 4'h1)
                        state <= ST_SETTLE;
                    init_cnt <= init_cnt - 4'h1;
                end
                ST_SETTLE:
                begin
                    if (!bus_init_seen)
                        state <= ST_RUN;
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // Internal reset pulse output
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            chip_reset_out <= 1'b0;
        else
            chip_reset_out <= (state == ST_INIT);
    end

    // Sticky status; set wins over software clear
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            error_status_reg <= RST_ERR_STATUS;
        else
        begin
            error_status_reg <= (error_status_reg
                & ~(wr_hit(reg_addr_in, OFS_ERR_CLEAR, reg_write_in)
                    ? reg_wdata_in : 16'h0000))
                | {15'h0000, expander_parity_err_in}
                | (wr_hit(reg_addr_in, OFS_ERR_INJECT, reg_write_in)
                    ? reg_wdata_in : 16'h0000);
        end
    end

    // Error logs capture first event only until cleared
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            first_error_log  <= RST_LOG;
            second_error_log <= RST_LOG;
        end
        else
        begin
            if (first_err_evt_in && first_error_log == 16'h0000)
                first_error_log <= first_err_info_in;
            else if (wr_hit(reg_addr_in, OFS_FIRST_LOG, reg_write_in))
                first_error_log <= 16'h0000;
            if (second_err_evt_in && second_error_log == 16'h0000)
                second_error_log <= second_err_info_in;
            else if (wr_hit(reg_addr_in, OFS_SECOND_LOG, reg_write_in))
                second_error_log <= 16'h0000;
        end
    end

    // Monitor pins from retained state, never masked by internal reset
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            err_n_out <= 2'b11;
        else
        begin
            err_n_out[0] <= !(|error_status_reg);
            err_n_out[1] <= !(|first_error_log || |second_error_log);
        end
    end

    // Driven config and command registers
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            driven_config_reg <= RST_DRIVEN_CFG;
            error_command_reg <= 16'h0000;
        end
        else
        begin
            if (wr_hit(reg_addr_in, OFS_DRIVEN_CFG, reg_write_in))
                driven_config_reg <= reg_wdata_in;
            if (wr_hit(reg_addr_in, OFS_ERR_STATUS, reg_write_in))
                error_command_reg <= reg_wdata_in;
        end
    end

    // Address line 10 capture at release of system reset
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            sys_reset_q         <= 1'b0;
            captured_config_reg <= 16'h0000;
        end
        else
        begin
            sys_reset_q <= sys_reset_in;
            if (sys_reset_q && !sys_reset_in)
                captured_config_reg[BIT_BUS_INIT_EN] <= addr10_in;
        end
    end

    // Drive address line 10 while system reset is active
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            addr10_out    <= 1'b0;
            addr10_oe_out <= 1'b0;
        end
        else
        begin
            addr10_out    <= 1'b1;
            addr10_oe_out <= sys_reset_in
                && driven_config_reg[BIT_BUS_INIT_EN];
        end
    end

    // Bus-init driven low on parity error when enabled
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            bus_init_n_out    <= 1'b1;
            bus_init_n_oe_out <= 1'b0;
        end
        else
        begin
            bus_init_n_out    <= 1'b0;
            bus_init_n_oe_out <= expander_parity_err_in
                && error_command_reg[BIT_BUS_INIT_N_ON_ERR];
        end
    end

    // Register read, data in the cycle after the strobe
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            reg_rdata_out <= 16'h0000;
        else if (!reg_read_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_addr_in == OFS_ERR_STATUS)
            reg_rdata_out <= error_status_reg;
        else if (reg_addr_in == OFS_FIRST_LOG)
            reg_rdata_out <= first_error_log;
        else if (reg_addr_in == OFS_SECOND_LOG)
            reg_rdata_out <= second_error_log;
        else if (reg_addr_in == OFS_CAPTURED_CFG)
            reg_rdata_out <= captured_config_reg;
        else if (reg_addr_in == OFS_DRIVEN_CFG)
            reg_rdata_out <= driven_config_reg;
        else if (reg_addr_in == OFS_ERR_CLEAR)
            reg_rdata_out <= error_command_reg;
        else
            reg_rdata_out <= 16'h0000;
    end

endmodule : error_pin_bus_init_n_config

// File: bench/error_pin_bus_init_n_config_sva.sv
module error_pin_bus_init_n_config_sva (
    // Clock and power-on reset
    input wire logic        clk_sys_in,
    input wire logic        reset_in,
    // Watched inputs
    input wire logic        reg_write_in,
    input wire logic        expander_parity_err_in,
    input wire logic        first_err_evt_in,
    input wire logic [15:0] first_err_info_in,
    input wire logic        sys_reset_in,
    input wire logic        bus_init_n_in,
    // Watched outputs
    input wire logic        bus_init_n_out,
    input wire logic        bus_init_n_oe_out,
    input wire logic        addr10_out,
    input wire logic        addr10_oe_out,
    input wire logic [1:0]  err_n_out,
    input wire logic        chip_reset_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_d;
    wire logic calm = !reg_write_in && !wr_d;
    // Remembers last cycle's write so a clear can land on the pins
    always_ff @(posedge clk_sys_in) wr_d <= reg_write_in;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    a_parity_flag: assert property (
        expander_parity_err_in |-> ##[1:2] !err_n_out[0])
        else $error("parity error not shown on pin");
    a_status_hold: assert property (
        !err_n_out[0] && calm |=> !err_n_out[0])
        else $error("status pin dropped without clear");
    a_log_hold: assert property (
        !err_n_out[1] && calm |=> !err_n_out[1])
        else $error("log pin dropped without clear");
    a_log_flag: assert property (
        first_err_evt_in && |first_err_info_in |-> ##[1:2] !err_n_out[1])
        else $error("log event not shown on pin");
    a_bus_init_n_seen: assert property (
        $fell(bus_init_n_in) && !chip_reset_out |-> ##[1:3] chip_reset_out)
        else $error("bus init not observed");
    a_init_len: assert property (
        $rose(chip_reset_out) |-> chip_reset_out[*8] ##1 !chip_reset_out)
        else $error("internal reset length wrong");
    a_addr_drive: assert property (
        addr10_oe_out |-> addr10_out && $past(sys_reset_in))
        else $error("address line driven outside reset");
    a_bus_init_n_drive: assert property (
        bus_init_n_oe_out |-> !bus_init_n_out && $past(expander_parity_err_in))
        else $error("bus init driven without parity error");
    c_init: cover property ($rose(chip_reset_out));
    c_addr: cover property (addr10_oe_out);
    c_drive: cover property (bus_init_n_oe_out);
endmodule : error_pin_bus_init_n_config_sva
bind error_pin_bus_init_n_config error_pin_bus_init_n_config_sva chk_i (.*);

// File: bench/far_side_model.sv
module far_side_model (
    // Chipset pins and board inputs
    input  wire logic bus_init_n_oe_in,
    input  wire logic agent_n_in,
    input  wire logic addr_oe_in,
    input  wire logic addr_drv_in,
    input  wire logic strap_in,
    // Resolved wire levels
    output logic      bus_init_n_n_out,
    output logic      addr10_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulled-up bus-init wire: any agent or the chipset pulls it low
    assign bus_init_n_n_out = agent_n_in && !bus_init_n_oe_in;
    // Address line 10: chipset drive wins over the board strap
    assign addr10_out = addr_oe_in ? addr_drv_in : strap_in;
endmodule : far_side_model

// File: bench/error_pin_bus_init_n_config_tb.sv
module error_pin_bus_init_n_config_tb
    import err_bus_init_n_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_in, reset_in, reg_write_in, reg_read_in;
    logic [3:0]  reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    logic [15:0] first_err_info_in, second_err_info_in;
    logic        expander_parity_err_in, first_err_evt_in, second_err_evt_in;
    logic        sys_reset_in, bus_init_n_in, bus_init_n_out;
    logic        bus_init_n_oe_out, addr10_in, addr10_out, addr10_oe_out;
    logic        chip_reset_out, agent_n, strap;
    logic [1:0]  err_n_out;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    // Write offset, write data, read offset, expected read data
    logic [39:0] rows [6] = '{40'h4_0400_4_0400, 40'hF_FFFF_F_0000,
        40'h3_FFFF_3_0000, 40'h6_0001_0_0001, 40'h5_0001_0_0000,
        40'h0_0001_5_0001};
    error_pin_bus_init_n_config DUT (.*);
    far_side_model far (.bus_init_n_oe_in(bus_init_n_oe_out), .agent_n_in(agent_n),
        .addr_oe_in(addr10_oe_out), .addr_drv_in(addr10_out),
        .strap_in(strap), .bus_init_n_n_out(bus_init_n_in), .addr10_out(addr10_in));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_write_in <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_read_in <= 1'b0;
        #1 chk(reg_rdata_out, e);
    endtask : rdc
    task automatic results();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    // Clock and hang guard
    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            results();
        end
    end
    initial
    begin
        reset_in = 1'b1;
        {reg_write_in, reg_read_in, expander_parity_err_in} = 3'h0;
        {first_err_evt_in, second_err_evt_in, sys_reset_in} = 3'h0;
        {agent_n, strap, reg_addr_in} = 6'h20;
        {reg_wdata_in, first_err_info_in, second_err_info_in} = 48'h0;
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        #1 chk({14'h0, err_n_out}, 16'h0003);
        rdc(OFS_DRIVEN_CFG, RST_DRIVEN_CFG);
        foreach (rows[i])
        begin
            wr(rows[i][39:36], rows[i][35:20]);
            rdc(rows[i][19:16], rows[i][15:0]);
        end
        // Log event, then parity error with bus-init drive enabled
        @(posedge clk_sys_in);
        first_err_evt_in  <= 1'b1;
        first_err_info_in <= 16'hA5C3;
        @(posedge clk_sys_in);
        first_err_evt_in       <= 1'b0;
        expander_parity_err_in <= 1'b1;
        @(posedge clk_sys_in);
        expander_parity_err_in <= 1'b0;
        agent_n                <= 1'b0;
        #1 chk({15'h0, bus_init_n_oe_out}, 16'h0001);
        repeat (4) @(posedge clk_sys_in);
        #1 chk({13'h0, chip_reset_out, err_n_out}, 16'h0004);
        repeat (12) @(posedge clk_sys_in);
        agent_n <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 chk({14'h0, err_n_out}, 16'h0000);
        rdc(OFS_ERR_STATUS, 16'h0001);
        rdc(OFS_FIRST_LOG, 16'hA5C3);
        wr(OFS_ERR_CLEAR, 16'h0001);
        wr(OFS_FIRST_LOG, 16'h0000);
        @(posedge clk_sys_in);
        #1 chk({14'h0, err_n_out}, 16'h0003);
        // Second log keeps its first value until it is cleared
        @(posedge clk_sys_in);
        second_err_evt_in  <= 1'b1;
        second_err_info_in <= 16'h3C5A;
        @(posedge clk_sys_in);
        second_err_info_in <= 16'h1234;
        @(posedge clk_sys_in);
        second_err_evt_in <= 1'b0;
        rdc(OFS_SECOND_LOG, 16'h3C5A);
        #1 chk({14'h0, err_n_out}, 16'h0001);
        wr(OFS_SECOND_LOG, 16'h0000);
        // System reset with the drive enable set and the strap high
        @(posedge clk_sys_in);
        strap        <= 1'b1;
        sys_reset_in <= 1'b1;
        #1 chk({14'h0, err_n_out}, 16'h0003);
        repeat (3) @(posedge clk_sys_in);
        #1 chk({15'h0, addr10_oe_out}, 16'h0001);
        @(posedge clk_sys_in);
        sys_reset_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        rdc(OFS_CAPTURED_CFG, 16'h0400);
        // Read data stand one cycle only, then return to zero
        @(posedge clk_sys_in);
        #1 chk(reg_rdata_out, 16'h0000);
        results();
    end
endmodule : error_pin_bus_init_n_config_tb
